// ---- logic/glue_params.svh ----
`ifndef GLUE_PARAMS_SVH
`define GLUE_PARAMS_SVH

// memory windows, inclusive bounds
`define MON_ROM_LO        16'h0000
`define MON_ROM_HI        16'h1fff
`define ROM2_LO           16'h2000
`define ROM2_HI_8K        16'h3fff
`define ROM2_HI_4K        16'h2fff
`define SOCK3_RAM_LO      16'hf000
`define SOCK3_RAM_HI      16'hf7ff
`define SOCK3_ROM_LO      16'h4000
`define SOCK3_ROM_HI      16'h47ff
`define WORK_RAM_LO       16'hf800
`define WORK_RAM_HI       16'hffff

// i/o windows: base with the two low address bits as offset
`define IO_CHIP1_BASE     8'h80
`define IO_CHIP2_BASE     8'h90
`define IO_WIN_MASK       8'hfc
`define IO_OFS_A          2'h0
`define IO_OFS_B          2'h1
`define IO_OFS_C          2'h2
`define IO_OFS_CTRL       2'h3

// port c bit positions, and the mode bit of the control register
`define C1_SHIFT_BIT      4
`define C1_CONTROL_BIT    5
`define C2_KEY_RET0_BIT   0
`define C2_KEY_RET2_BIT   2
`define C2_TAPE_IN_BIT    3
`define C2_BREAK_BIT      4
`define C2_TONE_BIT       5
`define CTRL_MODE_BIT     7

// reset values of the port latches
`define PORT_A_RST        8'h00
`define PORT_B_RST        8'h00
`define PORT_C_RST        8'hff
`define CTRL_RST          8'h9b

// step counter
`define STEP_MODULUS      3'h5

// reset pulse width in ns, and the cycle count at 100 MHz
`define CLK_SYS_MHZ       100
`define RESET_PULSE_NS    2000
`define RESET_PULSE_CYC   ((`RESET_PULSE_NS * `CLK_SYS_MHZ + 999) / 1000)

`endif

// ---- logic/glue_pkg.sv ----
package glue_pkg;

    typedef struct packed {
        logic work_ram;
        logic sock3;
        logic rom2;
        logic mon_rom;
    } mem_sel_t;

    typedef struct packed {
        logic [7:0] port_a;
        logic [7:0] port_b;
        logic [7:0] port_c;
        logic [7:0] ctrl;
    } port_chip_t;

    typedef enum logic [1:0] {
        IO_NONE,
        IO_CHIP1,
        IO_CHIP2
    } io_chip_t;

    typedef enum logic [1:0] {
        RST_POWER,
        RST_PULSE,
        RST_IDLE
    } rst_state_t;

endpackage

// ---- logic/trainer_glue.sv ----
// Our own choices: the strobed register port and the register addresses.
`timescale 1ns/100ps
`include "glue_params.svh"
module trainer_glue
    import glue_pkg::*;
#(
    parameter int RESET_PULSE_CYCLES = `RESET_PULSE_CYC
) (
    input  wire logic        clk_sys,
    input  wire logic        nrst,
    // cpu memory side
    input  wire logic [15:0] mem_addr,
    input  wire logic        mem_req,
    input  wire logic        rom2_is_8k,
    input  wire logic        sock3_is_rom,
    output mem_sel_t         mem_sel_q,
    // cpu i/o side, plain register port
    input  wire logic [15:0] io_addr,
    input  wire logic [7:0]  io_wdata,
    input  wire logic        io_wr,
    input  wire logic        io_rd,
    output logic      [7:0]  io_rdata_q,
    // loose inputs read through port c
    input  wire logic        shift_key,
    input  wire logic        control_key,
    input  wire logic        key_return0,
    input  wire logic        key_return2,
    input  wire logic        tape_input_bit,
    // display and sound
    output logic      [19:0] digit_sel_q,
    output logic      [14:0] segment_q,
    output logic             tone_out_q,
    output logic             tone_output_bit_q,
    output logic             break_control_bit_q,
    // single step
    input  wire logic        opcode_fetch_strobe_n,
    output logic             nmi_n_q,
    // clock and reset shaping
    output logic             cpu_clk_q,
    input  wire logic        reset_key,
    output logic             cpu_reset_n_q,
    output logic             port_reset_q
);

    function automatic logic in_range(input logic [15:0] a, input logic [15:0] lo, input logic [15:0] hi);
        in_range = (a >= lo) && (a <= hi);
    endfunction

    function automatic mem_sel_t decode_mem(input logic [15:0] a, input logic big2, input logic s3rom);
        mem_sel_t s;
        s = '0;
        s.mon_rom  = in_range(a, `MON_ROM_LO, `MON_ROM_HI);
        s.rom2     = in_range(a, `ROM2_LO, big2 ? `ROM2_HI_8K : `ROM2_HI_4K);
        s.sock3    = s3rom ? in_range(a, `SOCK3_ROM_LO, `SOCK3_ROM_HI)
                           : in_range(a, `SOCK3_RAM_LO, `SOCK3_RAM_HI);
        s.work_ram = in_range(a, `WORK_RAM_LO, `WORK_RAM_HI);
        decode_mem = s;
    endfunction

    // only the low byte is compared, so the windows repeat every 256 ports
    function automatic io_chip_t decode_io(input logic [15:0] a);
        if ((a[7:0] & `IO_WIN_MASK) == `IO_CHIP1_BASE) begin
            decode_io = IO_CHIP1;
        end else if ((a[7:0] & `IO_WIN_MASK) == `IO_CHIP2_BASE) begin
            decode_io = IO_CHIP2;
        end else begin
            decode_io = IO_NONE;
        end
    endfunction

    // a write to port chip: latch port, or bit set/reset on control with mode bit clear
    function automatic port_chip_t chip_write(input port_chip_t c, input logic [1:0] ofs, input logic [7:0] d);
        port_chip_t n;
        n = c;
        case (ofs)
            `IO_OFS_A: n.port_a = d;
            `IO_OFS_B: n.port_b = d;
            `IO_OFS_C: n.port_c = d;
            default: begin
                if (d[`CTRL_MODE_BIT]) begin
                    // a mode set clears the output latches, as the parts do
                    n.ctrl   = d;
                    n.port_a = '0;
                    n.port_b = '0;
                    n.port_c = '0;
                end else begin
                    n.port_c[d[3:1]] = d[0];
                end
            end
        endcase
        chip_write = n;
    endfunction

    localparam port_chip_t CHIP_RST = '{port_a: `PORT_A_RST, port_b: `PORT_B_RST,
                                        port_c: `PORT_C_RST, ctrl: `CTRL_RST};

    port_chip_t chip1_q;
    port_chip_t chip2_q;
    io_chip_t   io_sel;
    logic [7:0] port_c1_in;
    logic [7:0] port_c2_in;
    logic [7:0] rdata_d;

    assign io_sel = decode_io(io_addr);

    // memory decode, registered so the selects come straight from flops
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            mem_sel_q <= '0;
        end else if (mem_req) begin
            mem_sel_q <= decode_mem(mem_addr, rom2_is_8k, sock3_is_rom);
        end else begin
            mem_sel_q <= '0;
        end
    end

    // port latches; the shaped port reset restores them for a warm start
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            chip1_q <= CHIP_RST;
            chip2_q <= CHIP_RST;
        end else if (port_reset_q) begin
            chip1_q <= CHIP_RST;
            chip2_q <= CHIP_RST;
        end else if (io_wr) begin
            if (io_sel == IO_CHIP1) begin
                chip1_q <= chip_write(chip1_q, io_addr[1:0], io_wdata);
            end
            if (io_sel == IO_CHIP2) begin
                chip2_q <= chip_write(chip2_q, io_addr[1:0], io_wdata);
            end
        end
    end

    // port c read views: inputs replace the latch on their bits, unused bits read zero
    always_comb begin
        port_c1_in = {2'b00, 2'b00, chip1_q.port_c[3:0]};
        port_c1_in[`C1_SHIFT_BIT]   = shift_key;
        port_c1_in[`C1_CONTROL_BIT] = control_key;
        port_c2_in = 8'h00;
        port_c2_in[`C2_KEY_RET0_BIT] = key_return0;
        port_c2_in[`C2_KEY_RET2_BIT] = key_return2;
        port_c2_in[`C2_TAPE_IN_BIT]  = tape_input_bit;
        port_c2_in[`C2_BREAK_BIT]    = chip2_q.port_c[`C2_BREAK_BIT];
        port_c2_in[`C2_TONE_BIT]     = chip2_q.port_c[`C2_TONE_BIT];
    end

    always_comb begin
        rdata_d = 8'h00;
        case (io_sel)
            IO_CHIP1: begin
                case (io_addr[1:0])
                    `IO_OFS_A: rdata_d = chip1_q.port_a;
                    `IO_OFS_B: rdata_d = chip1_q.port_b;
                    `IO_OFS_C: rdata_d = port_c1_in;
                    default:   rdata_d = chip1_q.ctrl;
                endcase
            end
            IO_CHIP2: begin
                case (io_addr[1:0])
                    `IO_OFS_A: rdata_d = chip2_q.port_a;
                    `IO_OFS_B: rdata_d = {1'b0, chip2_q.port_b[6:0]};
                    `IO_OFS_C: rdata_d = port_c2_in;
                    default:   rdata_d = chip2_q.ctrl;
                endcase
            end
            default: rdata_d = 8'h00;
        endcase
    end

    // read data stands only in the cycle after the read strobe
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            io_rdata_q <= 8'h00;
        end else if (io_rd) begin
            io_rdata_q <= rdata_d;
        end else begin
            io_rdata_q <= 8'h00;
        end
    end

    // pin drive follows the latches one clock later
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            digit_sel_q <= '0;
        end else begin
            digit_sel_q <= {chip1_q.port_c[3:0], chip1_q.port_b, chip1_q.port_a};
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            segment_q <= '0;
        end else begin
            segment_q <= {chip2_q.port_b[6:0], chip2_q.port_a};
        end
    end

    // tape, speaker and led all hang off the one tone bit, driven both straight and inverted
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            tone_output_bit_q <= 1'b1;
            tone_out_q        <= 1'b0;
        end else begin
            tone_output_bit_q <= chip2_q.port_c[`C2_TONE_BIT];
            tone_out_q        <= ~chip2_q.port_c[`C2_TONE_BIT];
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            break_control_bit_q <= 1'b1;
        end else begin
            break_control_bit_q <= chip2_q.port_c[`C2_BREAK_BIT];
        end
    end

    // step counter: three low stages mod five plus a top stage
    logic       fetch_prev_q;
    logic       fetch_fall;
    logic       break_ctl;
    logic [2:0] low_q;
    logic       counter_top_stage;
    logic [2:0] low_d;
    logic       top_d;

    assign fetch_fall = fetch_prev_q && !opcode_fetch_strobe_n;
    // the latch is used, not the pin flop, so a clear is seen without extra delay
    assign break_ctl  = chip2_q.port_c[`C2_BREAK_BIT];

    always_comb begin
        low_d = low_q;
        top_d = counter_top_stage;
        if (break_ctl) begin
            low_d = 3'h0;
            top_d = 1'b0;
        end else if (fetch_fall) begin
            if (low_q == `STEP_MODULUS - 3'h1) begin
                low_d = 3'h0;
                top_d = 1'b1;
            end else begin
                low_d = low_q + 3'h1;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            fetch_prev_q <= 1'b1;
        end else begin
            fetch_prev_q <= opcode_fetch_strobe_n;
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            low_q             <= 3'h0;
            counter_top_stage <= 1'b0;
        end else begin
            low_q             <= low_d;
            counter_top_stage <= top_d;
        end
    end

    // the interrupt is the inverted next top stage, so it lands on the fifth counted fetch
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            nmi_n_q <= 1'b1;
        end else begin
            nmi_n_q <= ~top_d;
        end
    end

    // cpu clock at half the system clock
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            cpu_clk_q <= 1'b0;
        end else begin
            cpu_clk_q <= ~cpu_clk_q;
        end
    end

    // reset shaping: power-up forces one pulse, the key forces another while held
    rst_state_t rst_state_q;
    logic [$clog2(RESET_PULSE_CYCLES+1)-1:0] rst_cnt_q;

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            rst_state_q <= RST_POWER;
            rst_cnt_q   <= '0;
        end else begin
            case (rst_state_q)
                RST_POWER: begin
                    rst_state_q <= RST_PULSE;
                    rst_cnt_q   <= '0;
                end
                RST_PULSE: begin
                    if (reset_key) begin
                        rst_cnt_q <= '0;
                    end else if (rst_cnt_q == $bits(rst_cnt_q)'(RESET_PULSE_CYCLES - 1)) begin
                        rst_state_q <= RST_IDLE;
                    end else begin
                        rst_cnt_q <= rst_cnt_q + 1'b1;
                    end
                end
                RST_IDLE: begin
                    if (reset_key) begin
                        rst_state_q <= RST_PULSE;
                        rst_cnt_q   <= '0;
                    end
                end
                default: rst_state_q <= RST_POWER;
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            cpu_reset_n_q <= 1'b0;
            port_reset_q  <= 1'b1;
        end else begin
            cpu_reset_n_q <= (rst_state_q == RST_IDLE) && !reset_key;
            port_reset_q  <= (rst_state_q != RST_IDLE) || reset_key;
        end
    end

endmodule

// ---- dv/trainer_glue_chk.sv ----
`timescale 1ns/100ps
module trainer_glue_chk
    import glue_pkg::*;
(
    input wire logic        clk_sys,
    input wire logic        nrst,
    input wire logic [15:0] mem_addr,
    input wire logic        mem_req,
    input wire logic        rom2_is_8k,
    input wire logic        sock3_is_rom,
    input wire mem_sel_t    mem_sel_q,
    input wire logic        io_rd,
    input wire logic [7:0]  io_rdata_q,
    input wire logic        tone_out_q,
    input wire logic        tone_output_bit_q,
    input wire logic        break_control_bit_q,
    input wire logic        nmi_n_q,
    input wire logic        cpu_clk_q,
    input wire logic        reset_key,
    input wire logic        cpu_reset_n_q,
    input wire logic        port_reset_q
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!nrst);
    chk_mon_rom_hit: assert property (mem_req && mem_addr <= 16'h1fff |=> mem_sel_q == 4'b0001)
        else $error("monitor rom select wrong");
    chk_rom2_low: assert property (mem_req && mem_addr[15:12] == 4'h2 |=> mem_sel_q == 4'b0010)
        else $error("second rom low half wrong");
    chk_rom2_top: assert property (mem_req && mem_addr[15:12] == 4'h3 |=>
        mem_sel_q == {2'b00, $past(rom2_is_8k), 1'b0}) else $error("second rom top half wrong");
    chk_sock3_ram: assert property (mem_req && mem_addr[15:11] == 5'h1e |=>
        mem_sel_q == {1'b0, !$past(sock3_is_rom), 2'b00}) else $error("third socket ram window wrong");
    chk_sock3_rom: assert property (mem_req && mem_addr[15:11] == 5'h08 |=>
        mem_sel_q == {1'b0, $past(sock3_is_rom), 2'b00}) else $error("third socket rom window wrong");
    chk_work_ram: assert property (mem_req && mem_addr[15:11] == 5'h1f |=> mem_sel_q == 4'b1000)
        else $error("working ram select wrong");
    chk_no_req: assert property (!mem_req |=> mem_sel_q == 4'b0000)
        else $error("select without request");
    chk_rdata_idle: assert property (!io_rd |=> io_rdata_q == 8'h00)
        else $error("read data outside read cycle");
    chk_tone_pair: assert property (tone_out_q != tone_output_bit_q)
        else $error("tone output not inverted");
    chk_break_idle: assert property (break_control_bit_q [*2] |-> nmi_n_q)
        else $error("interrupt while break high");
    chk_clk_half: assert property (nrst |=> cpu_clk_q != $past(cpu_clk_q))
        else $error("cpu clock not toggling");
    chk_reset_pair: assert property (cpu_reset_n_q != port_reset_q)
        else $error("reset outputs not complementary");
    chk_key_reset: assert property (reset_key |=> !cpu_reset_n_q && port_reset_q)
        else $error("reset key not seen");
endmodule
bind trainer_glue trainer_glue_chk u_chk (.clk_sys(clk_sys), .nrst(nrst), .mem_addr(mem_addr),
    .mem_req(mem_req), .rom2_is_8k(rom2_is_8k), .sock3_is_rom(sock3_is_rom), .mem_sel_q(mem_sel_q),
    .io_rd(io_rd), .io_rdata_q(io_rdata_q), .tone_out_q(tone_out_q), .tone_output_bit_q(tone_output_bit_q),
    .break_control_bit_q(break_control_bit_q), .nmi_n_q(nmi_n_q), .cpu_clk_q(cpu_clk_q),
    .reset_key(reset_key), .cpu_reset_n_q(cpu_reset_n_q), .port_reset_q(port_reset_q));

// ---- dv/cpu_fetch_model.sv ----
`timescale 1ns/100ps
module cpu_fetch_model (
    input  wire logic clk_sys,
    input  wire logic nrst,
    input  wire logic fetch_req,
    output logic      opcode_fetch_strobe_n
);
    logic [2:0] cnt_q;
    // strobe low three cycles, then high at least two, so every fall is seen alone
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            cnt_q <= 3'h0;
            opcode_fetch_strobe_n <= 1'b1;
        end else begin
            if (fetch_req && cnt_q == 3'h0) begin
                cnt_q <= 3'h4;
            end else if (cnt_q != 3'h0) begin
                cnt_q <= cnt_q - 3'h1;
            end
            opcode_fetch_strobe_n <= !((fetch_req && cnt_q == 3'h0) || cnt_q > 3'h2);
        end
    end
endmodule

// ---- dv/trainer_glue_test.sv ----
`timescale 1ns/100ps
`define CHK(nm, exp, got) begin n_checks++; if ((got) !== (exp)) begin \
    $display("FAIL %s expected %h seen %h", nm, exp, got); num_errors++; end end
module trainer_glue_test
    import glue_pkg::*;
;
    logic        clk_sys = 0, nrst = 0, mem_req = 0, rom2_is_8k = 0, sock3_is_rom = 0;
    logic        io_wr = 0, io_rd = 0, shift_key = 0, control_key = 0, key_return0 = 0;
    logic        key_return2 = 0, tape_input_bit = 0, reset_key = 0, fetch_req = 0;
    logic [15:0] mem_addr = 0, io_addr = 0;
    logic [7:0]  io_wdata = 0, io_rdata_q;
    mem_sel_t    mem_sel_q;
    logic [19:0] digit_sel_q;
    logic [14:0] segment_q;
    logic        tone_out_q, tone_output_bit_q, break_control_bit_q, nmi_n_q, cpu_clk_q;
    logic        cpu_reset_n_q, port_reset_q, opcode_fetch_strobe_n;
    int          num_errors = 0, n_checks = 0;
    always #5 clk_sys = ~clk_sys;
    trainer_glue #(.RESET_PULSE_CYCLES(4)) u_dut (.clk_sys(clk_sys), .nrst(nrst), .mem_addr(mem_addr),
        .mem_req(mem_req), .rom2_is_8k(rom2_is_8k), .sock3_is_rom(sock3_is_rom), .mem_sel_q(mem_sel_q),
        .io_addr(io_addr), .io_wdata(io_wdata), .io_wr(io_wr), .io_rd(io_rd), .io_rdata_q(io_rdata_q),
        .shift_key(shift_key), .control_key(control_key), .key_return0(key_return0),
        .key_return2(key_return2), .tape_input_bit(tape_input_bit), .digit_sel_q(digit_sel_q),
        .segment_q(segment_q), .tone_out_q(tone_out_q), .tone_output_bit_q(tone_output_bit_q),
        .break_control_bit_q(break_control_bit_q), .opcode_fetch_strobe_n(opcode_fetch_strobe_n),
        .nmi_n_q(nmi_n_q), .cpu_clk_q(cpu_clk_q), .reset_key(reset_key), .cpu_reset_n_q(cpu_reset_n_q),
        .port_reset_q(port_reset_q));
    cpu_fetch_model u_cpu (.clk_sys(clk_sys), .nrst(nrst), .fetch_req(fetch_req),
        .opcode_fetch_strobe_n(opcode_fetch_strobe_n));
    task automatic complete_run();
        if (num_errors == 0 && n_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic settle(int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask
    task automatic io_put(logic [15:0] a, logic [7:0] d);
        @(posedge clk_sys);
        io_wr <= 1'b1;
        io_addr <= a;
        io_wdata <= d;
        @(posedge clk_sys);
        io_wr <= 1'b0;
    endtask
    task automatic io_get(string nm, logic [15:0] a, logic [7:0] e);
        @(posedge clk_sys);
        io_rd <= 1'b1;
        io_addr <= a;
        @(posedge clk_sys);
        io_rd <= 1'b0;
        #1;
        `CHK(nm, e, io_rdata_q)
    endtask
    task automatic mem_chk(logic [15:0] a, logic q, logic r8, logic s3, logic [3:0] e);
        @(posedge clk_sys);
        mem_addr <= a;
        mem_req <= q;
        rom2_is_8k <= r8;
        sock3_is_rom <= s3;
        settle(1);
        `CHK("mem_sel_q", e, mem_sel_q)
    endtask
    task automatic fetch();
        @(posedge clk_sys);
        fetch_req <= 1'b1;
        @(posedge clk_sys);
        fetch_req <= 1'b0;
        settle(5);
    endtask
    task automatic wait_rst();
        for (int i = 0; i < 100; i++) begin
            settle(1);
            if (cpu_reset_n_q === 1'b1) return;
        end
        $display("FAIL cpu_reset_n_q expected 1 seen %b", cpu_reset_n_q);
        num_errors++;
        complete_run();
    endtask
    task automatic t_power_on();
        settle(1);
        `CHK("cpu_reset_n_q", 1'b0, cpu_reset_n_q)
        wait_rst();
        `CHK("port_reset_q", 1'b0, port_reset_q)
        `CHK("tone_output_bit_q", 1'b1, tone_output_bit_q)
        `CHK("break_control_bit_q", 1'b1, break_control_bit_q)
    endtask
    task automatic t_mem();
        mem_chk(16'h0000, 1, 0, 0, 4'b0001);
        mem_chk(16'h1fff, 1, 0, 0, 4'b0001);
        mem_chk(16'h2000, 1, 0, 0, 4'b0010);
        mem_chk(16'h2fff, 1, 0, 0, 4'b0010);
        mem_chk(16'h3000, 1, 0, 0, 4'b0000);
        mem_chk(16'h3fff, 1, 1, 0, 4'b0010);
        mem_chk(16'hf000, 1, 0, 0, 4'b0100);
        mem_chk(16'hf7ff, 1, 0, 1, 4'b0000);
        mem_chk(16'h4000, 1, 0, 1, 4'b0100);
        mem_chk(16'h47ff, 1, 0, 1, 4'b0100);
        mem_chk(16'h4800, 1, 0, 1, 4'b0000);
        mem_chk(16'h4000, 1, 0, 0, 4'b0000);
        mem_chk(16'hf800, 1, 0, 1, 4'b1000);
        mem_chk(16'hffff, 1, 1, 0, 4'b1000);
        mem_chk(16'h0100, 0, 0, 0, 4'b0000);
    endtask
    task automatic t_io();
        io_put(16'h0080, 8'h5a);
        io_put(16'h0081, 8'hc3);
        io_put(16'h1282, 8'h0f);
        io_put(16'h0090, 8'h55);
        io_put(16'h0091, 8'hff);
        io_put(16'h0084, 8'h77);
        settle(2);
        `CHK("digit_sel_q", {4'hf, 8'hc3, 8'h5a}, digit_sel_q)
        `CHK("segment_q", {7'h7f, 8'h55}, segment_q)
        io_get("port1_a", 16'h0080, 8'h5a);
        io_get("port2_b", 16'h0091, 8'h7f);
        io_get("unmapped", 16'h0084, 8'h00);
        io_get("ctrl2", 16'h0093, 8'h9b);
        io_put(16'h0083, 8'h80);
        settle(2);
        `CHK("digit_sel_q", 20'h00000, digit_sel_q)
        io_get("ctrl1", 16'h0083, 8'h80);
    endtask
    task automatic t_portc();
        @(posedge clk_sys);
        shift_key <= 1'b1;
        tape_input_bit <= 1'b1;
        key_return0 <= 1'b1;
        io_get("port1_c", 16'h0082, 8'h10);
        io_get("port2_c", 16'h0092, 8'h39);
        @(posedge clk_sys);
        shift_key <= 1'b0;
        control_key <= 1'b1;
        tape_input_bit <= 1'b0;
        key_return0 <= 1'b0;
        key_return2 <= 1'b1;
        io_get("port1_c", 16'h0082, 8'h20);
        io_put(16'h0093, 8'h0a);
        settle(2);
        `CHK("tone_out_q", 1'b1, tone_out_q)
        io_get("port2_c", 16'h0092, 8'h14);
        io_put(16'h0093, 8'h0b);
    endtask
    task automatic t_step();
        io_put(16'h0093, 8'h08);
        settle(2);
        `CHK("break_control_bit_q", 1'b0, break_control_bit_q)
        for (int i = 1; i <= 6; i++) begin
            fetch();
            `CHK("nmi_n_q", 1'(i < 5), nmi_n_q)
        end
        io_put(16'h0093, 8'h09);
        settle(2);
        `CHK("nmi_n_q", 1'b1, nmi_n_q)
        for (int i = 0; i < 5; i++) fetch();
        `CHK("nmi_n_q", 1'b1, nmi_n_q)
        io_put(16'h0093, 8'h08);
        for (int i = 0; i < 4; i++) fetch();
        `CHK("nmi_n_q", 1'b1, nmi_n_q)
        fetch();
        `CHK("nmi_n_q", 1'b0, nmi_n_q)
        io_put(16'h0093, 8'h09);
    endtask
    task automatic t_reset_key();
        io_put(16'h0080, 8'hff);
        @(posedge clk_sys);
        reset_key <= 1'b1;
        settle(3);
        `CHK("cpu_reset_n_q", 1'b0, cpu_reset_n_q)
        `CHK("port_reset_q", 1'b1, port_reset_q)
        @(posedge clk_sys);
        reset_key <= 1'b0;
        wait_rst();
        `CHK("digit_sel_q", 20'hf0000, digit_sel_q)
    endtask
    initial begin
        repeat (8) @(posedge clk_sys);
        nrst <= 1'b1;
        t_power_on();
        t_mem();
        t_io();
        t_portc();
        t_step();
        t_reset_key();
        complete_run();
    end
endmodule
